// ==== hdl/dgp_pkg.sv ====
// register map, field layout, reset values and timing constants of the gpio port
package dgp_pkg;
	localparam logic [15:0] DGP_P0_LEVEL_ADDR = 16'h5200;
	localparam logic [15:0] DGP_P0_DRIVE_ADDR = 16'h5201;
	localparam logic [15:0] DGP_P0_DRVON_ADDR = 16'h5202;
	localparam logic [15:0] DGP_P0_PULLUP_ADDR = 16'h5203;
	localparam logic [15:0] DGP_P0_HYST_ADDR = 16'h5204;
	localparam logic [15:0] DGP_P0_IRQMASK_ADDR = 16'h5205;
	localparam logic [15:0] DGP_PORT0_EDGE_POLARITY_ADDR = 16'h5206;
	localparam logic [15:0] DGP_P0_PEND_ADDR = 16'h5207;
	localparam logic [15:0] DGP_P0_DEBOUNCE_ADDR = 16'h5208;
	localparam logic [15:0] DGP_P0_KEYRST_ADDR = 16'h5209;
	localparam logic [15:0] DGP_P0_RXON_ADDR = 16'h520a;
	localparam logic [15:0] DGP_P1_LEVEL_ADDR = 16'h5210;
	localparam logic [15:0] DGP_P1_DRIVE_ADDR = 16'h5211;
	localparam logic [15:0] DGP_P1_DRVON_ADDR = 16'h5212;
	localparam logic [15:0] DGP_P1_PULLUP_ADDR = 16'h5213;
	localparam logic [7:0] DGP_ZERO_RST = 8'h00;
	localparam logic [7:0] DGP_ONES_RST = 8'hff;
	localparam int DGP_UPPER_FIELD_LSB = 4;
	localparam int DGP_LOWER_FIELD_LSB = 0;
	localparam logic [7:0] DGP_DEBOUNCE_MASK = 8'h77;
	localparam logic [7:0] DGP_KEYRST_MASK = 8'h03;
	localparam logic [1:0] DGP_KEY_OFF = 2'h0;
	localparam logic [1:0] DGP_KEY_PINS1 = 2'h1;
	localparam logic [1:0] DGP_KEY_PINS2 = 2'h2;
	localparam logic [1:0] DGP_KEY_PINS3 = 2'h3;
	// base filter time in peripheral-clock periods for setting 1
	localparam int DGP_FILTER_BASE_CYCLES = 256;
	localparam int DGP_FILTER_CNT_W = 15;
endpackage : dgp_pkg

// ==== hdl/dgp_gpio_port.sv ====
// two-port gpio block with edge interrupts, debounce and key-entry reset
// Overview of operation
// RULE1: port0 level register reads present pin levels
// RULE2: port0 drive value register, reset zero
// RULE3: port0 driver enable register, reset zero
// RULE4: port0 pull-up enable register, reset ones
// RULE5: port0 schmitt select register, reset ones
// RULE6: port0 interrupt enable mask, reset zero
// RULE7: edge select: one falling, zero rising
// RULE8: edge sets flag; write one clears
// RULE9: upper nibble filter time field encoding
// RULE10: lower nibble filter field, same encoding
// RULE11: key-entry reset when selected pins low
// RULE12: port0 input enable register, reset ones
// RULE13: port1 level register reads pin levels
// RULE14: port1 drive value register, reset zero
// RULE15: port1 driver enable register, reset zero
// RULE16: port1 pull-up enable register, reset ones
// RULE17: interrupt when flag and enable both set
// RULE18: filtered level passes after stable time
// RULE19: reserved bits read zero, writes ignored
`timescale 1ns/10ps
module dgp_gpio_port
	import dgp_pkg::*;
#(
	parameter int FILTER_BASE = DGP_FILTER_BASE_CYCLES
)
(
	input wire logic clk_in, // peripheral clock
	input wire logic sys_rst_in, // synchronous reset, high
	input wire logic [15:0] addr_in, // register address
	input wire logic [7:0] wdata_in, // write data
	input wire logic wr_in, // write strobe
	input wire logic rd_in, // read strobe
	output logic [7:0] rdata_out, // read data, cycle after strobe
	input wire logic [7:0] p0_pin_in, // port0 pin levels
	output logic [7:0] p0_pin_out, // port0 drive levels
	output logic [7:0] p0_pin_oe_n_out, // port0 driver enable, low drives
	output logic [7:0] p0_pullup_out, // port0 pull-up enables
	output logic [7:0] p0_schmitt_out, // port0 schmitt selects
	output logic [7:0] p0_rx_on_out, // port0 input enables
	input wire logic [7:0] p1_pin_in, // port1 pin levels
	output logic [7:0] p1_pin_out, // port1 drive levels
	output logic [7:0] p1_pin_oe_n_out, // port1 driver enable, low drives
	output logic [7:0] p1_pullup_out, // port1 pull-up enables
	output logic irq_out, // port0 interrupt request, level
	output logic key_reset_out // key-entry reset request, level
);
	logic [7:0] port0_drive_value_reg;
	logic [7:0] port0_driver_on_reg;
	logic [7:0] port0_pullup_on_reg;
	logic [7:0] port0_hysteresis_reg;
	logic [7:0] port0_irq_mask_reg;
	logic [7:0] port0_edge_polarity_reg;
	logic [7:0] port0_irq_pending_reg;
	logic [2:0] upper_nibble_debounce_field;
	logic [2:0] lower_nibble_debounce_field;
	logic [1:0] key_reset_select_field;
	logic [7:0] port0_receiver_on_reg;
	logic [7:0] port1_drive_value_reg;
	logic [7:0] port1_driver_on_reg;
	logic [7:0] port1_pullup_on_reg;
	logic [7:0] filt_level_reg;
	logic [7:0] filt_prev_reg;
	logic [7:0] edge_event;
	logic [7:0] rise_seen;
	logic [7:0] fall_seen;
	logic [7:0] p0_gated;
	logic key_low;
	logic [DGP_FILTER_CNT_W-1:0] lim_upper;
	logic [DGP_FILTER_CNT_W-1:0] lim_lower;
	logic [7:0] rdata_next;
	logic wr_p0_pend;

	// filter limit: setting n gives base shifted left by n-1 bits
	function automatic logic [DGP_FILTER_CNT_W-1:0] filt_limit(
		input logic [2:0] sel
	);
		logic [DGP_FILTER_CNT_W-1:0] base;
		base = DGP_FILTER_CNT_W'(FILTER_BASE);
		if (sel == 3'h0)
			filt_limit = '0;
		else
			filt_limit = base << (sel - 3'h1); // RULE9
	endfunction

	// longest limit is base shifted by six, still inside the counter
	assign lim_upper = filt_limit(upper_nibble_debounce_field);
	assign lim_lower = filt_limit(lower_nibble_debounce_field); // RULE10
	// a disabled receiver reads low, as a gated input buffer would
	assign p0_gated = p0_pin_in & port0_receiver_on_reg; // RULE12

	// upper nibble pins share one limit, lower nibble pins the other
	for (genvar g = 0; g < 8; g++)
	begin : g_filt
		dgp_pin_filter #(
			.CNT_W(DGP_FILTER_CNT_W)
		) u_filt (
			.clk_in(clk_in),
			.sys_rst_in(sys_rst_in),
			.raw_in(p0_gated[g]),
			.limit_in((g >= 4) ? lim_upper : lim_lower),
			.level_out(filt_level_reg[g])
		);
	end

	// reset takes the live level too, so no false edge follows reset
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			filt_prev_reg <= p0_gated;
		else
			filt_prev_reg <= filt_level_reg;
	end

	// rising edge when polarity 0, falling when 1
	assign rise_seen = filt_level_reg & ~filt_prev_reg;
	assign fall_seen = ~filt_level_reg & filt_prev_reg;
	assign edge_event = (~port0_edge_polarity_reg & rise_seen)
		| (port0_edge_polarity_reg & fall_seen); // RULE7

	// one decode shared by the clear path
	assign wr_p0_pend = wr_in && (addr_in == DGP_P0_PEND_ADDR);

	// flags clear only by writing ones, never by a read
	// a new edge wins over a clear in the same cycle
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			port0_irq_pending_reg <= DGP_ZERO_RST;
		else if (wr_p0_pend)
			port0_irq_pending_reg <= (port0_irq_pending_reg & ~wdata_in)
				| edge_event; // RULE8
		else
			port0_irq_pending_reg <= port0_irq_pending_reg | edge_event;
	end

	// registered, so the request lags the flags by one cycle
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			irq_out <= 1'b0;
		else
			irq_out <= |(port0_irq_pending_reg & port0_irq_mask_reg); // RULE17
	end

	// key-entry reset looks only at the selected low-order pins
	always_comb
	begin
		key_low = 1'b0;
		case (key_reset_select_field) // RULE11
			DGP_KEY_PINS3: key_low = ~|filt_level_reg[3:0];
			DGP_KEY_PINS2: key_low = ~|filt_level_reg[2:0];
			DGP_KEY_PINS1: key_low = ~|filt_level_reg[1:0];
			default: key_low = 1'b0;
		endcase
	end

	// registered so the reset request comes from a flop
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			key_reset_out <= 1'b0;
		else
			key_reset_out <= key_low; // RULE11
	end

	// port0 pin configuration registers
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			port0_drive_value_reg <= DGP_ZERO_RST; // RULE2
			port0_driver_on_reg <= DGP_ZERO_RST; // RULE3
			port0_pullup_on_reg <= DGP_ONES_RST; // RULE4
			port0_hysteresis_reg <= DGP_ONES_RST; // RULE5
			port0_receiver_on_reg <= DGP_ONES_RST; // RULE12
		end
		else if (wr_in)
		begin
			if (addr_in == DGP_P0_DRIVE_ADDR)
				port0_drive_value_reg <= wdata_in;
			else if (addr_in == DGP_P0_DRVON_ADDR)
				port0_driver_on_reg <= wdata_in;
			else if (addr_in == DGP_P0_PULLUP_ADDR)
				port0_pullup_on_reg <= wdata_in;
			else if (addr_in == DGP_P0_HYST_ADDR)
				port0_hysteresis_reg <= wdata_in;
			else if (addr_in == DGP_P0_RXON_ADDR)
				port0_receiver_on_reg <= wdata_in;
		end
	end

	// port0 interrupt configuration: enables and edge polarity
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			port0_irq_mask_reg <= DGP_ZERO_RST; // RULE6
			port0_edge_polarity_reg <= DGP_ZERO_RST; // RULE7
		end
		else if (wr_in)
		begin
			if (addr_in == DGP_P0_IRQMASK_ADDR)
				port0_irq_mask_reg <= wdata_in;
			else if (addr_in == DGP_PORT0_EDGE_POLARITY_ADDR)
				port0_edge_polarity_reg <= wdata_in;
		end
	end

	// filter fields; reserved bits 7 and 3 are never stored
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			upper_nibble_debounce_field <= 3'h0; // RULE9
			lower_nibble_debounce_field <= 3'h0; // RULE10
		end
		else if (wr_in && addr_in == DGP_P0_DEBOUNCE_ADDR)
		begin
			upper_nibble_debounce_field <=
				wdata_in[DGP_UPPER_FIELD_LSB +: 3]; // RULE19
			lower_nibble_debounce_field <=
				wdata_in[DGP_LOWER_FIELD_LSB +: 3];
		end
	end

	// only the two low bits of the key select exist
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			key_reset_select_field <= DGP_KEY_OFF;
		else if (wr_in && addr_in == DGP_P0_KEYRST_ADDR)
			key_reset_select_field <= wdata_in[1:0]; // RULE11
	end

	// port1 has no interrupt or filter logic in this block
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			port1_drive_value_reg <= DGP_ZERO_RST; // RULE14
			port1_driver_on_reg <= DGP_ZERO_RST; // RULE15
			port1_pullup_on_reg <= DGP_ONES_RST; // RULE16
		end
		else if (wr_in)
		begin
			if (addr_in == DGP_P1_DRIVE_ADDR)
				port1_drive_value_reg <= wdata_in;
			else if (addr_in == DGP_P1_DRVON_ADDR)
				port1_driver_on_reg <= wdata_in;
			else if (addr_in == DGP_P1_PULLUP_ADDR)
				port1_pullup_on_reg <= wdata_in;
		end
	end

	// unmapped addresses and reserved bits fall through to zero
	always_comb
	begin
		rdata_next = 8'h00;
		if (addr_in == DGP_P0_LEVEL_ADDR)
			rdata_next = p0_gated; // RULE1
		else if (addr_in == DGP_P0_DRIVE_ADDR)
			rdata_next = port0_drive_value_reg;
		else if (addr_in == DGP_P0_DRVON_ADDR)
			rdata_next = port0_driver_on_reg;
		else if (addr_in == DGP_P0_PULLUP_ADDR)
			rdata_next = port0_pullup_on_reg;
		else if (addr_in == DGP_P0_HYST_ADDR)
			rdata_next = port0_hysteresis_reg;
		else if (addr_in == DGP_P0_IRQMASK_ADDR)
			rdata_next = port0_irq_mask_reg;
		else if (addr_in == DGP_PORT0_EDGE_POLARITY_ADDR)
			rdata_next = port0_edge_polarity_reg;
		else if (addr_in == DGP_P0_PEND_ADDR)
			rdata_next = port0_irq_pending_reg;
		else if (addr_in == DGP_P0_DEBOUNCE_ADDR)
			rdata_next = {1'b0, upper_nibble_debounce_field, 1'b0,
				lower_nibble_debounce_field} & DGP_DEBOUNCE_MASK; // RULE19
		else if (addr_in == DGP_P0_KEYRST_ADDR)
			rdata_next = {6'h00, key_reset_select_field} & DGP_KEYRST_MASK;
		else if (addr_in == DGP_P0_RXON_ADDR)
			rdata_next = port0_receiver_on_reg;
		else if (addr_in == DGP_P1_LEVEL_ADDR)
			rdata_next = p1_pin_in; // RULE13
		else if (addr_in == DGP_P1_DRIVE_ADDR)
			rdata_next = port1_drive_value_reg;
		else if (addr_in == DGP_P1_DRVON_ADDR)
			rdata_next = port1_driver_on_reg;
		else if (addr_in == DGP_P1_PULLUP_ADDR)
			rdata_next = port1_pullup_on_reg;
	end

	// read data holds only in the cycle after the strobe
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			rdata_out <= 8'h00;
		else if (rd_in)
			rdata_out <= rdata_next;
		else
			rdata_out <= 8'h00;
	end

	// pin controls mirror the registers one cycle later
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			p0_pin_out <= DGP_ZERO_RST;
			p0_pin_oe_n_out <= DGP_ONES_RST;
			p0_pullup_out <= DGP_ONES_RST;
			p0_schmitt_out <= DGP_ONES_RST;
			p0_rx_on_out <= DGP_ONES_RST;
		end
		else
		begin
			p0_pin_out <= port0_drive_value_reg; // RULE2
			p0_pin_oe_n_out <= ~port0_driver_on_reg; // RULE3
			p0_pullup_out <= port0_pullup_on_reg; // RULE4
			p0_schmitt_out <= port0_hysteresis_reg; // RULE5
			p0_rx_on_out <= port0_receiver_on_reg; // RULE12
		end
	end

	// port1 outputs, same one-cycle lag as port0
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			p1_pin_out <= DGP_ZERO_RST;
			p1_pin_oe_n_out <= DGP_ONES_RST;
			p1_pullup_out <= DGP_ONES_RST;
		end
		else
		begin
			p1_pin_out <= port1_drive_value_reg; // RULE14
			p1_pin_oe_n_out <= ~port1_driver_on_reg; // RULE15
			p1_pullup_out <= port1_pullup_on_reg; // RULE16
		end
	end
endmodule // dgp_gpio_port

// one pin's debounce: a new level passes after holding for the limit
module dgp_pin_filter
	import dgp_pkg::*;
#(
	parameter int CNT_W = DGP_FILTER_CNT_W
)
(
	input wire logic clk_in, // peripheral clock
	input wire logic sys_rst_in, // synchronous reset, high
	input wire logic raw_in, // gated pin level
	input wire logic [CNT_W-1:0] limit_in, // stable cycles, zero: none
	output logic level_out // filtered level
);
	logic [CNT_W-1:0] hold_cnt_reg;
	logic pass_now;

	// limit zero lets a change through after one cycle
	assign pass_now = (raw_in != level_out)
		&& (limit_in == '0 || hold_cnt_reg >= limit_in - 1'b1);

	// counter only runs while raw and filtered levels differ
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			hold_cnt_reg <= '0;
		else if (raw_in == level_out || pass_now)
			hold_cnt_reg <= '0;
		else
			hold_cnt_reg <= hold_cnt_reg + 1'b1;
	end

	// reset loads the live level so no false edge follows reset
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			level_out <= raw_in;
		else if (pass_now)
			level_out <= raw_in; // RULE18
	end
endmodule // dgp_pin_filter

// ==== sim/dgp_gpio_port_props.sv ====
// assertion checker for the gpio port bus and pin paths
`timescale 1ns/10ps
module dgp_gpio_port_props
	import dgp_pkg::*;
(
	input wire logic clk_in, // clock
	input wire logic sys_rst_in, // reset
	input wire logic [15:0] addr_in, // address
	input wire logic [7:0] wdata_in, // write data
	input wire logic wr_in, // write
	input wire logic rd_in, // read
	input wire logic [7:0] rdata_out, // read data
	input wire logic [7:0] p0_pin_out, // p0 drive
	input wire logic [7:0] p0_pin_oe_n_out, // p0 enable
	input wire logic [7:0] p0_schmitt_out, // p0 schmitt
	input wire logic [7:0] p0_rx_on_out, // p0 input on
	input wire logic [7:0] p1_pin_out // p1 drive
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	AST_P0_DRIVE:
	assert property (wr_in && addr_in == DGP_P0_DRIVE_ADDR |-> ##2
		p0_pin_out == $past(wdata_in, 2)) else $error("p0 drive");
	AST_P0_DRVON:
	assert property (wr_in && addr_in == DGP_P0_DRVON_ADDR |=> ##1
		p0_pin_oe_n_out == ~$past(wdata_in, 2)) else $error("p0 enable");
	AST_P0_HYST:
	assert property (wr_in && addr_in == DGP_P0_HYST_ADDR |-> ##2
		p0_schmitt_out == $past(wdata_in, 2)) else $error("p0 schmitt");
	AST_P0_RXON:
	assert property (wr_in && addr_in == DGP_P0_RXON_ADDR |-> ##2
		p0_rx_on_out == $past(wdata_in, 2)) else $error("p0 input on");
	AST_P1_DRIVE:
	assert property (wr_in && addr_in == DGP_P1_DRIVE_ADDR |=> ##1
		p1_pin_out == $past(wdata_in, 2)) else $error("p1 drive");
	AST_RD_IDLE:
	assert property (!$past(rd_in) |-> rdata_out == 8'h00)
		else $error("read data outside slot");
	AST_KEY_RSV:
	assert property (rd_in && addr_in == DGP_P0_KEYRST_ADDR |=>
		rdata_out[7:2] == 6'h00) else $error("key reserved bits");
	AST_DEB_RSV:
	assert property (rd_in && addr_in == DGP_P0_DEBOUNCE_ADDR |=>
		!rdata_out[7] && !rdata_out[3]) else $error("filter reserved");
endmodule // dgp_gpio_port_props

bind dgp_gpio_port dgp_gpio_port_props u_props (.*);

// ==== sim/dgp_pin_model.sv ====
// external pin model: drivers, pull-ups, keys to ground, open lines
`timescale 1ns/10ps
module dgp_pin_model
(
	input wire logic clk_in, // clock
	input wire logic [7:0] drv_in, // drive levels
	input wire logic [7:0] oe_n_in, // low drives
	input wire logic [7:0] pu_in, // pull-ups
	input wire logic [7:0] press_in, // keys closed
	output logic [7:0] lvl_out // pin levels
);
	logic flt_reg = 1'b0;
	// an open line wanders, so a stale level never passes for a read
	always_ff @(posedge clk_in)
		flt_reg <= ~flt_reg;
	always_comb
		for (int i = 0; i < 8; i++)
			lvl_out[i] = !oe_n_in[i] ? drv_in[i] :
				press_in[i] ? 1'b0 : pu_in[i] | flt_reg;
endmodule // dgp_pin_model

// ==== sim/dgp_gpio_port_tb.sv ====
// self-checking bench for the two-port gpio block
`timescale 1ns/10ps
module dgp_gpio_port_tb;
	logic clk_in = 1'b0, sys_rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
	logic [15:0] addr_in = 16'h0000;
	logic [7:0] wdata_in = 8'h00, press = 8'h00;
	logic [7:0] rdata_out, p0_pin_in, p0_pin_out, p0_pin_oe_n_out;
	logic [7:0] p0_pullup_out, p0_schmitt_out, p0_rx_on_out, p1_pin_in;
	logic [7:0] p1_pin_out, p1_pin_oe_n_out, p1_pullup_out;
	logic irq_out, key_reset_out;
	int miscompares = 0, compares = 0;
	// address, reset value, writable mask (zero: read-only or unmapped)
	logic [15:0] ta [15] = '{16'h5200, 16'h5201, 16'h5202, 16'h5203,
		16'h5204, 16'h5205, 16'h5206, 16'h5208, 16'h5209, 16'h520a,
		16'h5210, 16'h5211, 16'h5212, 16'h5213, 16'h520b};
	logic [7:0] tr [15] = '{8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00,
		8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00};
	logic [7:0] tm [15] = '{8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'hff, 8'h77, 8'h03, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00};
	always #5 clk_in = ~clk_in;
	dgp_gpio_port #(.FILTER_BASE(2)) dut (.*);
	dgp_pin_model u_p0 (.clk_in(clk_in), .drv_in(p0_pin_out),
		.oe_n_in(p0_pin_oe_n_out), .pu_in(p0_pullup_out),
		.press_in(press), .lvl_out(p0_pin_in));
	dgp_pin_model u_p1 (.clk_in(clk_in), .drv_in(p1_pin_out),
		.oe_n_in(p1_pin_oe_n_out), .pu_in(p1_pullup_out),
		.press_in(8'h00), .lvl_out(p1_pin_in));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h",
				$time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		chk(rdata_out, e);
	endtask
	task automatic hold(input logic [7:0] p, input int n);
		@(posedge clk_in);
		press <= p;
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic report_and_stop;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic t_regs;
		rd(16'h5207, 8'h00);
		for (int i = 0; i < 15; i++)
		begin
			rd(ta[i], tr[i]);
			wr(ta[i], 8'h5a);
			rd(ta[i], tm[i] == 8'h00 ? tr[i] : tm[i] & 8'h5a);
			wr(ta[i], tr[i]);
		end
		$display("register test done");
	endtask
	task automatic t_pins;
		wr(16'h5202, 8'h0f);
		wr(16'h5201, 8'h05);
		wr(16'h5203, 8'h0f);
		wr(16'h520a, 8'h0f);
		wr(16'h5212, 8'hff);
		wr(16'h5211, 8'ha5);
		rd(16'h5200, 8'h05);
		rd(16'h5210, 8'ha5);
		chk(p0_pin_oe_n_out, 8'hf0);
		chk(p0_pullup_out, 8'h0f);
		chk(p1_pullup_out, 8'hff);
		chk(p1_pin_oe_n_out, 8'h00);
		chk(p0_rx_on_out, 8'h0f);
		for (int i = 0; i < 15; i++)
			wr(ta[i], tr[i]);
		$display("pin test done");
	endtask
	task automatic t_irq;
		wr(16'h5207, 8'hff);
		wr(16'h5205, 8'h01);
		hold(8'h01, 4);
		rd(16'h5207, 8'h00);
		hold(8'h00, 4);
		rd(16'h5207, 8'h01);
		chk({7'h00, irq_out}, 8'h01);
		wr(16'h5207, 8'hfe);
		rd(16'h5207, 8'h01);
		wr(16'h5205, 8'h00);
		hold(8'h00, 2);
		chk({7'h00, irq_out}, 8'h00);
		wr(16'h5206, 8'h01);
		wr(16'h5207, 8'h01);
		hold(8'h01, 4);
		rd(16'h5207, 8'h01);
		hold(8'h00, 4);
		wr(16'h5207, 8'hff);
		rd(16'h5207, 8'h00);
		$display("interrupt test done");
	endtask
	task automatic t_filt;
		// setting 3 with base 2: eight stable cycles before a level passes
		wr(16'h5208, 8'h33);
		wr(16'h5205, 8'h11);
		wr(16'h5206, 8'h11);
		hold(8'h11, 4);
		hold(8'h00, 12);
		rd(16'h5207, 8'h00);
		hold(8'h11, 12);
		rd(16'h5207, 8'h11);
		wr(16'h5208, 8'h00);
		$display("filter test done");
	endtask
	task automatic t_key;
		for (int s = 1; s < 4; s++)
		begin
			wr(16'h5209, 8'(s));
			hold(8'((2 << s) - 1) >> 1, 4);
			chk({7'h00, key_reset_out}, 8'h00);
			hold(8'((2 << s) - 1), 4);
			chk({7'h00, key_reset_out}, 8'h01);
		end
		wr(16'h5209, 8'h00);
		hold(8'h0f, 4);
		chk({7'h00, key_reset_out}, 8'h00);
		$display("key reset test done");
	endtask
	initial
	begin
		repeat (16) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		t_regs;
		t_pins;
		t_irq;
		t_filt;
		t_key;
		report_and_stop;
	end
	// all tests need well under 1000 cycles
	initial
	begin
		repeat (5000) @(posedge clk_in);
		miscompares++;
		report_and_stop;
	end
endmodule // dgp_gpio_port_tb
